// ---- uart_consts.vh ----
// register map, field positions and reset values of the standard uart block
//
// Summary of operation
// - frame is start zero, data bits, optional parity, then stop ones
// - idle transmit line is held at one
// - data width programmable 4 to 9 bits, default eight
// - stop period in half-bit steps from one to four bits
// - transmit parity: select 0 even, select 1 odd over data bits
// - parity bit sits right after last data bit, before stop
// - receiver checks parity with its own enable and odd select
// - bad-parity frame kept when drop is 0, discarded when 1
// - parity only in standard and smart-card variants, off in infrared
// - receiver resynchronises on each stop-to-start falling edge
// - receiver oversamples line by programmable factor
// - median filter votes three samples around bit middle
// - both ends use the same baud rate from own clocks
// - clear-to-send acts only on transmitter, active means far side ready
// - ready-to-send driven by receiver while it can accept data
// - flow control never suspends reception
// - internal block clock only, fifo buffer mode only
// - ready-to-send active while rx fifo count below threshold
// - with cts gating, start needs cts active and tx fifo not empty
// - rts and cts polarity selectable, default active low
`ifndef UART_CONSTS_VH
`define UART_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL        8'h00
`define OFS_TX_CTRL     8'h04
`define OFS_RX_CTRL     8'h08
`define OFS_OVS         8'h0C
`define OFS_FLOW        8'h10
`define OFS_STATUS      8'h14
`define OFS_TX_WR       8'h18
`define OFS_RX_RD       8'h1C
`define OFS_RX_PEEK     8'h20
`define OFS_TX_FSTAT    8'h24
`define OFS_RX_FSTAT    8'h28

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTRL_EN         0
`define CTRL_MODE_LO    1
`define CTRL_MODE_HI    2
`define MODE_IRDA       2'h2
`define XC_WIDTH_HI     3
`define XC_STOP_LO      4
`define XC_STOP_HI      7
`define XC_PAR_EN       8
`define XC_PAR_ODD      9
`define XC_DROP         10
`define XC_MEDIAN       11
`define FL_TRIG_HI      7
`define FL_CTS_EN       16
`define FL_RTS_POL      24
`define FL_CTS_POL      25
`define FS_EMPTY        16
`define FS_FULL         17

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define RST_CTRL        3'h0
`define RST_WIDTH       4'h8
`define RST_STOP        4'h2
`define RST_OVS         8'h10
`define RST_TRIG        8'h08
`define MIN_WIDTH       4'h4
`define MAX_WIDTH       4'h9
`define MIN_STOP        4'h2
`define MAX_STOP        4'h8
`define MIN_OVS         8'h04

`endif

// ---- sync_fifo.v ----
// synchronous fifo with registered read data
`timescale 1ns/100ps
module sync_fifo #(
    parameter W     = 9,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire          core_clk,
    input  wire          srst,
    input  wire          push,
    input  wire [W-1:0]  wdata,
    input  wire          pop,
    output reg  [W-1:0]  rdata,
    output reg  [AW:0]   count,
    output wire          full,
    output wire          empty
);
    reg [W-1:0]  mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    wire         do_push;
    wire         do_pop;

    assign full    = (count == DEPTH[AW:0]);
    assign empty   = (count == {(AW+1){1'b0}});
    assign do_push = push & ~full;
    assign do_pop  = pop & ~empty;

    // pointers and occupancy
    always @(posedge core_clk) begin
        if (srst) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count    <= {(AW+1){1'b0}};
        end else begin
            if (do_push)
                wr_ptr_r <= wr_ptr_r + 1'b1;
            if (do_pop)
                rd_ptr_r <= rd_ptr_r + 1'b1;
            if (do_push & ~do_pop)
                count <= count + 1'b1;
            else if (do_pop & ~do_push)
                count <= count - 1'b1;
        end
    end

    // storage, head word registered one cycle behind pointer
    always @(posedge core_clk) begin
        if (do_push)
            mem[wr_ptr_r] <= wdata;
        rdata <= mem[rd_ptr_r];
    end
endmodule // sync_fifo

// ---- std_uart.v ----
// standard uart transmitter and receiver with apb registers and flow control
`timescale 1ns/100ps
`include "uart_consts.vh"
module std_uart #(
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire         core_clk,
    input  wire         srst,
    input  wire [7:0]   paddr,
    input  wire         psel,
    input  wire         penable,
    input  wire         pwrite,
    input  wire [31:0]  pwdata,
    output reg  [31:0]  prdata,
    output wire         pready,
    output wire         pslverr,
    output reg          uart_tx,
    input  wire         uart_rx,
    input  wire         cts_in,
    output reg          rts_out
);
    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    localparam S_IDLE  = 3'd0;
    localparam S_LOAD  = 3'd1;
    localparam S_START = 3'd2;
    localparam S_DATA  = 3'd3;
    localparam S_PAR   = 3'd4;
    localparam S_STOP  = 3'd5;

    // ----------------------------------------------------------------
    // registers and nets
    // ----------------------------------------------------------------
    reg  [2:0]    ctrl_r;
    reg  [3:0]    tx_width_r;
    reg  [3:0]    tx_stop_r;
    reg           tx_par_en_r;
    reg           tx_par_odd_r;
    reg  [3:0]    rx_width_r;
    reg           rx_par_en_r;
    reg           rx_par_odd_r;
    reg           rx_drop_r;
    reg           rx_median_r;
    reg  [7:0]    ovs_r;
    reg  [7:0]    trig_r;
    reg           cts_en_r;
    reg           rts_pol_r;
    reg           cts_pol_r;
    reg  [3:0]    sticky_r;
    reg           wait_r;
    reg  [2:0]    tx_st_r;
    reg  [7:0]    tx_cnt_r;
    reg  [3:0]    tx_bits_r;
    reg  [8:0]    tx_sh_r;
    reg           tx_par_r;
    reg  [2:0]    rx_st_r;
    reg  [7:0]    rx_cnt_r;
    reg  [3:0]    rx_bits_r;
    reg  [8:0]    rx_sh_r;
    reg           rx_par_r;
    reg           rx_prev_r;
    reg  [1:0]    rx_smp_r;
    reg  [31:0]   rd_mux;
    reg           mapped;
    wire          acc;
    wire          fire;
    wire          wr_fire;
    wire          rd_fire;
    wire          enable;
    wire          irda;
    wire          tx_par_on;
    wire          rx_par_on;
    wire [7:0]    ovs_eff;
    wire [7:0]    half;
    wire [7:0]    mid;
    wire [3:0]    tx_w;
    wire [3:0]    rx_w;
    wire [3:0]    stop_h;
    wire [8:0]    tx_mask;
    wire [8:0]    rx_mask;
    wire          tx_push;
    wire          tx_pop;
    wire [8:0]    tx_head;
    wire [AW:0]   tx_count;
    wire          tx_full;
    wire          tx_empty;
    wire          rx_push;
    wire          rx_pop;
    wire [8:0]    rx_head;
    wire [AW:0]   rx_count;
    wire          rx_full;
    wire          rx_empty;
    wire          cts_active;
    wire          tx_go;
    wire          tx_bit_end;
    wire          tx_half_end;
    wire          rx_fall;
    wire          rx_decide;
    wire          rx_bit;
    wire          rx_bit_end;
    wire          rx_exp_par;
    wire          rx_perr;
    wire          rx_ferr;
    wire          rx_frame_done;
    wire          rx_keep;
    wire [3:0]    sticky_set;

    // ----------------------------------------------------------------
    // apb slave
    // ----------------------------------------------------------------
    // one wait state: answer on the second access cycle
    assign acc     = psel & penable;
    assign fire    = acc & wait_r;
    assign pready  = fire;
    assign pslverr = fire & ~mapped;
    assign wr_fire = fire & pwrite & mapped;
    assign rd_fire = fire & ~pwrite & mapped;

    always @(posedge core_clk) begin
        if (srst)
            wait_r <= 1'b0;
        else
            wait_r <= acc & ~wait_r;
    end

    // address decode and read mux
    always @* begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            `OFS_CTRL:     rd_mux[2:0] = ctrl_r;
            `OFS_TX_CTRL:  rd_mux[9:0] = {tx_par_odd_r, tx_par_en_r, tx_stop_r, tx_width_r};
            `OFS_RX_CTRL:  rd_mux[11:0] = {rx_median_r, rx_drop_r, rx_par_odd_r, rx_par_en_r,
                                           4'h0, rx_width_r};
            `OFS_OVS:      rd_mux[7:0] = ovs_r;
            `OFS_FLOW:     rd_mux = {6'h00, cts_pol_r, rts_pol_r, 7'h00, cts_en_r, 8'h00, trig_r};
            `OFS_STATUS:   rd_mux[9:0] = {(rx_st_r != S_IDLE), (tx_st_r != S_IDLE), 4'h0, sticky_r};
            `OFS_TX_WR:    rd_mux = 32'h0000_0000;
            `OFS_RX_RD:    rd_mux[8:0] = rx_head;
            `OFS_RX_PEEK:  rd_mux[8:0] = rx_head;
            `OFS_TX_FSTAT: rd_mux[17:0] = {tx_full, tx_empty, {(16-AW-1){1'b0}}, tx_count};
            `OFS_RX_FSTAT: rd_mux[17:0] = {rx_full, rx_empty, {(16-AW-1){1'b0}}, rx_count};
            default:       mapped = 1'b0;
        endcase
    end

    // read data captured in the first access cycle
    always @(posedge core_clk) begin
        if (srst)
            prdata <= 32'h0000_0000;
        else if (acc & ~wait_r & ~pwrite)
            prdata <= rd_mux;
    end

    // configuration registers
    always @(posedge core_clk) begin
        if (srst) begin
            ctrl_r       <= `RST_CTRL;
            tx_width_r   <= `RST_WIDTH;
            tx_stop_r    <= `RST_STOP;
            tx_par_en_r  <= 1'b0;
            tx_par_odd_r <= 1'b0;
            rx_width_r   <= `RST_WIDTH;
            rx_par_en_r  <= 1'b0;
            rx_par_odd_r <= 1'b0;
            rx_drop_r    <= 1'b0;
            rx_median_r  <= 1'b0;
            ovs_r        <= `RST_OVS;
            trig_r       <= `RST_TRIG;
            cts_en_r     <= 1'b0;
            rts_pol_r    <= 1'b0;
            cts_pol_r    <= 1'b0;
        end else if (wr_fire) begin
            case (paddr)
                `OFS_CTRL:    ctrl_r <= pwdata[`CTRL_MODE_HI:`CTRL_EN];
                `OFS_TX_CTRL: begin
                    tx_width_r   <= pwdata[`XC_WIDTH_HI:0];
                    tx_stop_r    <= pwdata[`XC_STOP_HI:`XC_STOP_LO];
                    tx_par_en_r  <= pwdata[`XC_PAR_EN];
                    tx_par_odd_r <= pwdata[`XC_PAR_ODD];
                end
                `OFS_RX_CTRL: begin
                    rx_width_r   <= pwdata[`XC_WIDTH_HI:0];
                    rx_par_en_r  <= pwdata[`XC_PAR_EN];
                    rx_par_odd_r <= pwdata[`XC_PAR_ODD];
                    rx_drop_r    <= pwdata[`XC_DROP];
                    rx_median_r  <= pwdata[`XC_MEDIAN];
                end
                `OFS_OVS:     ovs_r <= pwdata[7:0];
                `OFS_FLOW: begin
                    trig_r    <= pwdata[`FL_TRIG_HI:0];
                    cts_en_r  <= pwdata[`FL_CTS_EN];
                    rts_pol_r <= pwdata[`FL_RTS_POL];
                    cts_pol_r <= pwdata[`FL_CTS_POL];
                end
                default: ;
            endcase
        end
    end

    // sticky status, write one to clear, a new event wins over the clear
    assign sticky_set = {tx_push & tx_full, rx_frame_done & rx_full & rx_keep,
                         rx_frame_done & rx_ferr, rx_frame_done & rx_perr};
    always @(posedge core_clk) begin
        if (srst)
            sticky_r <= 4'h0;
        else if (wr_fire && paddr == `OFS_STATUS)
            sticky_r <= (sticky_r & ~pwdata[3:0]) | sticky_set;
        else
            sticky_r <= sticky_r | sticky_set;
    end

    // ----------------------------------------------------------------
    // effective settings
    // ----------------------------------------------------------------
    assign enable    = ctrl_r[`CTRL_EN];
    assign irda      = (ctrl_r[`CTRL_MODE_HI:`CTRL_MODE_LO] == `MODE_IRDA);
    assign tx_par_on = tx_par_en_r & ~irda;
    assign rx_par_on = rx_par_en_r & ~irda;
    assign ovs_eff   = (ovs_r < `MIN_OVS) ? `MIN_OVS : ovs_r;
    assign half      = {1'b0, ovs_eff[7:1]};
    assign mid       = half;
    assign tx_w      = (tx_width_r < `MIN_WIDTH) ? `MIN_WIDTH :
                       (tx_width_r > `MAX_WIDTH) ? `MAX_WIDTH : tx_width_r;
    assign rx_w      = (rx_width_r < `MIN_WIDTH) ? `MIN_WIDTH :
                       (rx_width_r > `MAX_WIDTH) ? `MAX_WIDTH : rx_width_r;
    // stop length in half bits, 2..8
    assign stop_h    = (tx_stop_r < `MIN_STOP) ? `MIN_STOP :
                       (tx_stop_r > `MAX_STOP) ? `MAX_STOP : tx_stop_r;
    assign tx_mask   = 9'h1FF >> (`MAX_WIDTH - tx_w);
    assign rx_mask   = 9'h1FF >> (`MAX_WIDTH - rx_w);

    // ----------------------------------------------------------------
    // fifos
    // ----------------------------------------------------------------
    // fifo buffer mode only
    assign tx_push = wr_fire && (paddr == `OFS_TX_WR);
    assign tx_pop  = (tx_st_r == S_LOAD);
    assign rx_pop  = rd_fire && (paddr == `OFS_RX_RD);

    sync_fifo #(.W(9), .DEPTH(DEPTH), .AW(AW)) tx_fifo (
        .core_clk (core_clk),
        .srst     (srst),
        .push     (tx_push),
        .wdata    (pwdata[8:0]),
        .pop      (tx_pop),
        .rdata    (tx_head),
        .count    (tx_count),
        .full     (tx_full),
        .empty    (tx_empty)
    );

    sync_fifo #(.W(9), .DEPTH(DEPTH), .AW(AW)) rx_fifo (
        .core_clk (core_clk),
        .srst     (srst),
        .push     (rx_push),
        .wdata    (rx_sh_r & rx_mask),
        .pop      (rx_pop),
        .rdata    (rx_head),
        .count    (rx_count),
        .full     (rx_full),
        .empty    (rx_empty)
    );

    // ----------------------------------------------------------------
    // flow control
    // ----------------------------------------------------------------
    // polarity select, zero means active low
    assign cts_active = cts_pol_r ? cts_in : ~cts_in;
    // start gate on fifo and cts
    assign tx_go = enable & ~tx_empty & (~cts_en_r | cts_active);

    always @(posedge core_clk) begin
        if (srst)
            rts_out <= 1'b1;
        else
            rts_out <= rts_pol_r ~^ ({{(8-AW-1){1'b0}}, rx_count} < trig_r);
    end

    // ----------------------------------------------------------------
    // transmitter
    // ----------------------------------------------------------------
    // bits timed by own clock
    assign tx_bit_end  = (tx_cnt_r == ovs_eff - 8'h01);
    assign tx_half_end = (tx_cnt_r == half - 8'h01);

    always @(posedge core_clk) begin
        if (srst) begin
            tx_st_r   <= S_IDLE;
            tx_cnt_r  <= 8'h00;
            tx_bits_r <= 4'h0;
            tx_sh_r   <= 9'h000;
            tx_par_r  <= 1'b0;
            uart_tx   <= 1'b1;
        end else begin
            case (tx_st_r)
                S_IDLE: begin
                    uart_tx  <= 1'b1;
                    tx_cnt_r <= 8'h00;
                    if (tx_go)
                        tx_st_r <= S_LOAD;
                end
                S_LOAD: begin
                    tx_sh_r   <= tx_head & tx_mask;
                    // even when select is 0, odd when 1
                    tx_par_r  <= (^(tx_head & tx_mask)) ^ tx_par_odd_r;
                    tx_bits_r <= 4'h0;
                    uart_tx   <= 1'b0;
                    tx_st_r   <= S_START;
                end
                S_START: begin
                    tx_cnt_r <= tx_cnt_r + 8'h01;
                    if (tx_bit_end) begin
                        tx_cnt_r <= 8'h00;
                        uart_tx  <= tx_sh_r[0];
                        tx_st_r  <= S_DATA;
                    end
                end
                S_DATA: begin
                    tx_cnt_r <= tx_cnt_r + 8'h01;
                    if (tx_bit_end) begin
                        tx_cnt_r  <= 8'h00;
                        tx_sh_r   <= {1'b0, tx_sh_r[8:1]};
                        tx_bits_r <= tx_bits_r + 4'h1;
                        if (tx_bits_r == tx_w - 4'h1) begin
                            // parity right after last data bit
                            uart_tx <= tx_par_on ? tx_par_r : 1'b1;
                            tx_st_r <= tx_par_on ? S_PAR : S_STOP;
                            tx_bits_r <= 4'h0;  // stop half-bit count from zero
                        end else begin
                            uart_tx <= tx_sh_r[1];
                        end
                    end
                end
                S_PAR: begin
                    tx_cnt_r <= tx_cnt_r + 8'h01;
                    if (tx_bit_end) begin
                        tx_cnt_r  <= 8'h00;
                        tx_bits_r <= 4'h0;
                        uart_tx   <= 1'b1;
                        tx_st_r   <= S_STOP;
                    end
                end
                S_STOP: begin
                    // stop counted in half-bit units
                    uart_tx  <= 1'b1;
                    tx_cnt_r <= tx_cnt_r + 8'h01;
                    if (tx_half_end) begin
                        tx_cnt_r  <= 8'h00;
                        tx_bits_r <= tx_bits_r + 4'h1;
                        if (tx_bits_r == stop_h - 4'h1)
                            tx_st_r <= S_IDLE;
                    end
                end
                default: tx_st_r <= S_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // receiver
    // ----------------------------------------------------------------
    // falling edge resynchronises each frame
    assign rx_fall    = rx_prev_r & ~uart_rx;
    assign rx_decide  = (rx_cnt_r == mid + 8'h01);
    assign rx_bit_end = (rx_cnt_r == ovs_eff - 8'h01);
    assign rx_bit     = rx_median_r ? ((rx_smp_r[1] & rx_smp_r[0]) | (rx_smp_r[1] & uart_rx) |
                                       (rx_smp_r[0] & uart_rx)) : rx_smp_r[0];
    assign rx_exp_par = (^(rx_sh_r & rx_mask)) ^ rx_par_odd_r;
    assign rx_perr    = rx_par_on & (rx_par_r != rx_exp_par);
    assign rx_ferr    = ~rx_bit;
    assign rx_frame_done = (rx_st_r == S_STOP) & rx_decide;
    // drop only when drop setting is 1
    assign rx_keep    = ~(rx_perr & rx_drop_r);
    assign rx_push    = rx_frame_done & rx_keep;

    // mid-bit samples, before middle and at middle
    always @(posedge core_clk) begin
        if (srst) begin
            rx_prev_r <= 1'b1;
            rx_smp_r  <= 2'b11;
        end else begin
            rx_prev_r <= uart_rx;
            if (rx_cnt_r == mid - 8'h01)
                rx_smp_r[1] <= uart_rx;
            if (rx_cnt_r == mid)
                rx_smp_r[0] <= uart_rx;
        end
    end

    always @(posedge core_clk) begin
        if (srst) begin
            rx_st_r   <= S_IDLE;
            rx_cnt_r  <= 8'h00;
            rx_bits_r <= 4'h0;
            rx_sh_r   <= 9'h000;
            rx_par_r  <= 1'b0;
        end else begin
            rx_cnt_r <= rx_bit_end ? 8'h00 : rx_cnt_r + 8'h01;
            case (rx_st_r)
                S_IDLE: begin
                    rx_bits_r <= 4'h0;
                    rx_cnt_r  <= 8'h01;
                    if (enable & rx_fall)
                        rx_st_r <= S_START;
                end
                S_START: begin
                    if (rx_decide && rx_bit)
                        rx_st_r <= S_IDLE;
                    else if (rx_bit_end)
                        rx_st_r <= S_DATA;
                end
                S_DATA: begin
                    if (rx_decide)
                        rx_sh_r[rx_bits_r] <= rx_bit;
                    if (rx_bit_end) begin
                        rx_bits_r <= rx_bits_r + 4'h1;
                        if (rx_bits_r == rx_w - 4'h1)
                            rx_st_r <= rx_par_on ? S_PAR : S_STOP;
                    end
                end
                S_PAR: begin
                    if (rx_decide)
                        rx_par_r <= rx_bit;
                    if (rx_bit_end)
                        rx_st_r <= S_STOP;
                end
                S_STOP: begin
                    // frame ends at stop middle to catch the next edge early
                    if (rx_decide) begin
                        rx_st_r <= S_IDLE;
                        rx_sh_r <= 9'h000;
                    end
                end
                default: rx_st_r <= S_IDLE;
            endcase
        end
    end
endmodule // std_uart

// ---- std_uart_props.sv ----
// assertions on the uart block ports
`timescale 1ns/100ps
module std_uart_props (
    input core_clk,
    input srst,
    input psel,
    input penable,
    input pready,
    input pslverr,
    input uart_tx,
    input rts_out
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    // apb phases
    sequence setup_s; psel && !penable; endsequence
    sequence access_s; psel && penable; endsequence
    AST_ONE_WAIT: assert property (setup_s ##1 access_s |-> !pready ##1 pready) else $error("bad wait");
    AST_RDY_PULSE: assert property (pready |=> !pready) else $error("long pready");
    AST_ERR_QUAL: assert property (pslverr |-> pready) else $error("lone pslverr");
    AST_RDY_QUAL: assert property (pready |-> access_s ##0 $past(penable)) else $error("stray pready");
    AST_IDLE_RST: assert property ($fell(srst) |-> uart_tx) else $error("tx not idle");
    AST_RTS_RST: assert property ($fell(srst) |-> rts_out ##1 !rts_out) else $error("rts wrong");
    AST_BIT_HOLD: assert property ($changed(uart_tx) |=> $stable(uart_tx) [*3]) else $error("short bit");
    AST_STOP_HOLD: assert property ($rose(uart_tx) |-> uart_tx [*4]) else $error("short high");
endmodule // std_uart_props
bind std_uart std_uart_props i_std_uart_props (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .uart_tx(uart_tx), .rts_out(rts_out));

// ---- uart_peer.sv ----
// remote uart model at the far end of the link
`timescale 1ns/100ps
module uart_peer #(
    parameter BIT = 16
) (
    input      core_clk,
    input      line_in,
    output reg line_out
);
    initial line_out = 1'b1;
    task automatic send(input logic [11:0] b, input int n);
        for (int i = -1; i <= n; i++) begin
            line_out <= (i < 0) ? 1'b0 : (i == n) ? 1'b1 : b[i];
            repeat (BIT) @(posedge core_clk);
        end
    endtask
    task automatic recv(input int n, output logic [11:0] b, output logic ok);
        int t;
        t = 0;
        b = 12'h000;
        while (line_in !== 1'b0 && t < 3000) begin
            @(negedge core_clk);
            t++;
        end
        repeat (BIT / 2) @(negedge core_clk);
        ok = (t < 3000) && line_in === 1'b0;
        for (int i = 0; i <= n; i++) begin
            repeat (BIT) @(negedge core_clk);
            if (i < n) b[i] = line_in;
        end
        ok = ok && line_in === 1'b1;
    endtask
endmodule // uart_peer

// ---- std_uart_tb.sv ----
// self-checking bench for the standard uart block
`timescale 1ns/100ps
module std_uart_tb;
    logic        core_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, cts_in = 0, er, ok, p;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd, e;
    logic        pready, pslverr, uart_tx, uart_rx, rts_out;
    logic [11:0] got;
    logic [16:0] lfsr = 17'h1_46F7;
    int          err_total = 0, compares = 0;
    always #5 core_clk = ~core_clk;
    std_uart i_std_uart (.core_clk(core_clk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .uart_tx(uart_tx), .uart_rx(uart_rx), .cts_in(cts_in), .rts_out(rts_out));
    uart_peer i_uart_peer (.core_clk(core_clk), .line_in(uart_tx), .line_out(uart_rx));
    // random step and expected parity
    function automatic logic [16:0] rnd(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    function automatic logic par(input logic [8:0] d, input int w, input logic odd);
        par = odd;
        for (int i = 0; i < w; i++) par ^= d[i];
    endfunction
    // one apb transfer, answer taken at pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge core_clk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        do begin @(posedge core_clk); t++; end while (pready !== 1'b1 && t < 40);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        if (t >= 40) err_total++;
    endtask
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        compares++;
        if (g !== x) begin err_total++; $display("MISMATCH %s exp %h got %h", nm, x, g); end
    endtask
    task automatic summarize;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin #300000; err_total++; summarize; end
    initial begin
        repeat (4) @(posedge core_clk);
        srst <= 0;
        apb(0, 8'h04, 0); chk("tx_ctrl", 32'h0000_0028, rd);
        apb(0, 8'h10, 0); chk("flow", 32'h0000_0008, rd);
        apb(0, 8'h3C, 0); chk("slverr", 1, er);
        apb(1, 8'h00, 1);
        $display("registers done");
        for (int w = 4; w < 10; w++) for (int m = 0; m < 3; m++) begin
            lfsr = rnd(lfsr);
            e = ((w == 9 && m == 2) ? 9'h1FF : lfsr[8:0]) & ((1 << w) - 1);
            apb(1, 8'h04, 32'h0000_0020 | w | ((m > 0) << 8) | ((m == 2) << 9));
            apb(1, 8'h18, e);
            i_uart_peer.recv(w + (m > 0), got, ok);
            if (m > 0) e[w] = par(e[8:0], w, m == 2);
            chk("tx_frame", e, got);
            chk("tx_framing", 1, ok);
        end
        $display("transmit done");
        apb(1, 8'h04, 32'h0000_0028);
        apb(1, 8'h10, 32'h0001_0001);
        cts_in <= 1;
        apb(1, 8'h18, 32'h0000_00A5);
        repeat (60) @(posedge core_clk);
        chk("tx_gated", 1, uart_tx);
        apb(0, 8'h24, 0);
        chk("tx_held", 1, rd & 32'h0000_000F);
        for (int k = 0; k < 3; k++) begin
            lfsr = rnd(lfsr);
            apb(1, 8'h08, 32'h0000_0308 | ((k == 2) << 10) | ((k == 0) << 11));
            p = par(lfsr[8:0], 8, 1) ^ (k > 0);
            i_uart_peer.send({p, lfsr[7:0]}, 9);
            apb(0, 8'h28, 0); chk("rx_count", k < 2, rd & 32'h0000_000F);
            chk("rts", k < 2, rts_out);
            apb(0, 8'h1C, 0);
            if (k < 2) chk("rx_data", lfsr[7:0], rd);
        end
        apb(0, 8'h14, 0);
        chk("status", 32'h0000_0001, rd);
        apb(1, 8'h04, 32'h0000_0128);
        apb(1, 8'h00, 32'h0000_0005);
        cts_in <= 0;
        i_uart_peer.recv(8, got, ok); chk("tx_released", 32'h0000_00A5, got);
        chk("tx_no_parity", 1, ok);
        $display("receive and flow done");
        summarize;
    end
endmodule // std_uart_tb
